/* File: hw/cld_lock_detector.sv */
// Lock detector and acquisition control for a clock and data recovery
// receiver. Assumes clk is the divided recovered oscillator, the control
// bits come from a register block on clk, and the event pins are async.
//
// Summary of operation
// RULE1 - Error above upper threshold asserts loss, acquires
// RULE2 - Loss stays until error within lower threshold
// RULE3 - On lock, frequency loop off, phase loops on
// RULE4 - Normal mode locks to data, no reference
// RULE5 - Reference aiding only when lock-to-reference is one
// RULE6 - Host programs range and ratio with reference mode
// RULE7 - Reference mode compares against divided reference
// RULE8 - Reference mode relocks against reference after loss
// RULE9 - Sticky loss flag set on any loss
// RULE10 - One-then-zero on clear bit drops sticky flag
// RULE11 - Pin mode one mirrors sticky flag on pin
// RULE12 - Pin mode zero: pin shows live acquisition
// RULE13 - Sticky reads zero waiting, one once latched
// RULE14 - One-then-zero reset restarts acquisition, keeps settings
// RULE15 - Sequenced actions fire on fall to zero
`timescale 1ns/1ns
`default_nettype none
`include "cld_consts.svh"

module cld_lock_detector #(
    parameter int WIN_EVENTS       = `CLD_WIN_EVENTS,
    parameter int DATA_CYC_PER_EVT = `CLD_DATA_CYC_PER_EVT,
    parameter int REF_CYC_PER_EVT  = `CLD_REF_CYC_PER_EVT
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    // Asynchronous frequency markers
    input  wire logic                    dataMarker,
    input  wire logic                    reference_clock_input,
    // Control bits, same clock
    input  wire logic                    lockToRef,
    input  wire logic [`CLD_RANGE_W-1:0] refRange,
    input  wire logic [`CLD_RATIO_W-1:0] divRatio,
    input  wire logic                    pinStaticMode,
    input  wire logic                    clearStatic,
    input  wire logic                    systemReset,
    // Status and loop steering
    output logic                         loss_of_lock,
    output logic                         lolStatus,
    output logic                         staticLol,
    output logic                         fllEnable,
    output logic                         phaseLoopEnable
);

    localparam int CW = `CLD_CNT_W;

    cld_pkg::cld_state_t state_r;
    logic [1:0]    dataSync_r;
    logic [1:0]    refSync_r;
    logic          dataLast_r;
    logic          refLast_r;
    logic [7:0]    prescale_r;
    logic          clearLast_r;
    logic          resetLast_r;
    logic          modeLast_r;
    logic [CW-1:0] evtCnt_r;
    logic [CW-1:0] cycCnt_r;
    logic          resDone_r;
    logic          resOver_r;
    logic          resWithin_r;
    logic          staticLol_r;
    logic          lossOfLock_r;
    logic          fllEnable_r;
    logic          phaseEnable_r;
    logic          dataEvt;
    logic          refEdge;
    logic          refEvt;
    logic          measEvt;
    logic          clearFall;
    logic          resetFall;
    logic          restart;
    logic          lolRise;
    logic [7:0]    prescaleTop;
    logic [CW-1:0] expected;
    logic [CW-1:0] errAbs;
    logic          winEnd;

    // Limits the ratio exponent to the largest documented divide of 256
    function automatic logic [3:0] clampRatio(input logic [3:0] r);
        clampRatio = (r > `CLD_RATIO_MAX) ? `CLD_RATIO_MAX : r;
    endfunction

    // Marker pins cross in through two flops before any edge detection
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dataSync_r <= 2'h0;
            refSync_r  <= 2'h0;
            dataLast_r <= 1'b0;
            refLast_r  <= 1'b0;
        end else begin
            dataSync_r <= {dataSync_r[0], dataMarker};
            refSync_r  <= {refSync_r[0], reference_clock_input};
            dataLast_r <= dataSync_r[1];
            refLast_r  <= refSync_r[1];
        end
    end

    assign dataEvt = dataSync_r[1] & ~dataLast_r;
    assign refEdge = refSync_r[1] & ~refLast_r;

    // Reference prescaler refers the input band down by 2^range
    assign prescaleTop = 8'((8'h1 << refRange) - 8'h1);
    assign refEvt      = refEdge && (prescale_r >= prescaleTop);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prescale_r <= 8'h0;
        end else if (refEdge) begin
            prescale_r <= refEvt ? 8'h0 : prescale_r + 8'h1;
        end
    end

    // Reference edges steer the measurement only in reference mode
    assign measEvt = lockToRef ? refEvt : dataEvt; // RULE5 RULE4 RULE7

    // Expected oscillator cycles per window for the selected source
    always_comb begin
        if (lockToRef) begin
            expected = CW'(WIN_EVENTS) *
                (CW'(REF_CYC_PER_EVT) << clampRatio(divRatio)); // RULE7
        end else begin
            expected = CW'(WIN_EVENTS) * CW'(DATA_CYC_PER_EVT); // RULE4
        end
    end

    // Software strobes act on the one-to-zero step only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clearLast_r <= 1'b0;
            resetLast_r <= 1'b0;
            modeLast_r  <= 1'b0;
        end else begin
            clearLast_r <= clearStatic;
            resetLast_r <= systemReset;
            modeLast_r  <= lockToRef;
        end
    end

    assign clearFall = clearLast_r & ~clearStatic; // RULE15
    assign resetFall = resetLast_r & ~systemReset; // RULE15 RULE14
    // A source change would mix two frequencies in one window
    assign restart   = resetFall | (modeLast_r != lockToRef);

    // Window ends on the last event, or on timeout when markers stop
    assign winEnd = (measEvt && evtCnt_r == CW'(WIN_EVENTS - 1)) ||
                    (cycCnt_r >= (expected << 1));
    assign errAbs = (cycCnt_r > expected) ? cycCnt_r - expected
                                          : expected - cycCnt_r;

    // Counts oscillator cycles across a fixed number of marker events
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            evtCnt_r <= '0;
            cycCnt_r <= '0;
        end else if (restart) begin
            evtCnt_r <= '0;
            cycCnt_r <= '0;
        end else if (winEnd) begin
            // Start at one: this edge already belongs to the next span
            evtCnt_r <= '0;
            cycCnt_r <= CW'(1);
        end else begin
            cycCnt_r <= cycCnt_r + CW'(1);
            if (measEvt) begin
                evtCnt_r <= evtCnt_r + CW'(1);
            end
        end
    end

    // Window verdicts, scaled so no division is needed
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            resDone_r   <= 1'b0;
            resOver_r   <= 1'b0;
            resWithin_r <= 1'b0;
        end else begin
            resDone_r   <= winEnd && !restart;
            resOver_r   <= errAbs * CW'(`CLD_PPM_SCALE / `CLD_UPPER_PPM)
                           > expected; // RULE1 RULE8
            resWithin_r <= errAbs * CW'(`CLD_PPM_SCALE / `CLD_LOWER_PPM)
                           <= expected; // RULE2 RULE7
        end
    end

    // Hysteresis between acquire and track; restart holds off lock, a system reset fall forces acquisition
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= cld_pkg::CLD_ACQUIRE;
        end else begin
            case (state_r)
                cld_pkg::CLD_ACQUIRE: begin
                    if (!restart && resDone_r && resWithin_r) begin
                        state_r <= cld_pkg::CLD_TRACK; // RULE2 RULE7
                    end
                end
                cld_pkg::CLD_TRACK: begin
                    if (resetFall || (resDone_r && resOver_r)) begin
                        state_r <= cld_pkg::CLD_ACQUIRE; // RULE1 RULE8 RULE14
                    end
                end
                default: state_r <= cld_pkg::CLD_ACQUIRE;
            endcase
        end
    end

    assign lolRise = (state_r == cld_pkg::CLD_TRACK) &&
                     (resetFall || (resDone_r && resOver_r));

    // Sticky flag: a new loss in the clearing cycle wins over the clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            staticLol_r <= 1'b0;
        end else if (lolRise) begin
            staticLol_r <= 1'b1; // RULE9
        end else if (clearFall) begin
            staticLol_r <= 1'b0; // RULE10 RULE13
        end
    end

    // Pin and loop steering follow state one cycle later; in pin mode one the pin follows the sticky flag
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lossOfLock_r  <= 1'b1;
            fllEnable_r   <= 1'b1;
            phaseEnable_r <= 1'b0;
        end else begin
            lossOfLock_r  <= pinStaticMode ? staticLol_r // RULE11
                           : (state_r == cld_pkg::CLD_ACQUIRE); // RULE12
            fllEnable_r   <= (state_r == cld_pkg::CLD_ACQUIRE); // RULE3
            phaseEnable_r <= (state_r == cld_pkg::CLD_TRACK); // RULE3
        end
    end

    assign loss_of_lock    = lossOfLock_r;
    assign lolStatus       = fllEnable_r;
    assign staticLol       = staticLol_r;
    assign fllEnable       = fllEnable_r;
    assign phaseLoopEnable = phaseEnable_r;

    property p_lossOnOver;
        @(posedge clk) disable iff (!reset_n)
        (state_r == cld_pkg::CLD_TRACK && resDone_r && resOver_r)
            |=> (state_r == cld_pkg::CLD_ACQUIRE) ##1 fllEnable_r;
    endproperty
    a_lossOnOver: assert property (p_lossOnOver) // RULE1
        else $error("over-threshold error did not start acquisition");

    property p_holdInBand;
        @(posedge clk) disable iff (!reset_n)
        (state_r == cld_pkg::CLD_ACQUIRE && !(resDone_r && resWithin_r))
            |=> (state_r == cld_pkg::CLD_ACQUIRE);
    endproperty
    a_holdInBand: assert property (p_holdInBand) // RULE2
        else $error("loss released without in-band window");

    property p_loopHandover;
        @(posedge clk) disable iff (!reset_n)
        $rose(state_r == cld_pkg::CLD_TRACK)
            |=> !fllEnable_r && phaseEnable_r && !lolStatus;
    endproperty
    a_loopHandover: assert property (p_loopHandover) // RULE3
        else $error("frequency loop not handed over on lock");

    property p_lockInBand;
        @(posedge clk) disable iff (!reset_n)
        (state_r == cld_pkg::CLD_ACQUIRE && resDone_r && resWithin_r &&
         !restart) |=> (state_r == cld_pkg::CLD_TRACK);
    endproperty
    a_lockInBand: assert property (p_lockInBand) // RULE7
        else $error("in-band window did not release loss");

    property p_stickySet;
        @(posedge clk) disable iff (!reset_n)
        lolRise |=> staticLol_r ##1 (staticLol_r || $past(clearFall));
    endproperty
    a_stickySet: assert property (p_stickySet) // RULE9
        else $error("sticky flag missed a loss");

    property p_stickyClear;
        @(posedge clk) disable iff (!reset_n)
        (clearFall && !lolRise) |=> !staticLol_r;
    endproperty
    a_stickyClear: assert property (p_stickyClear) // RULE10
        else $error("sticky flag not cleared");

    property p_stickyHold;
        @(posedge clk) disable iff (!reset_n)
        (staticLol_r && !clearFall) |=> staticLol_r;
    endproperty
    a_stickyHold: assert property (p_stickyHold) // RULE13
        else $error("sticky flag dropped without clear");

    property p_clearWhileHigh;
        @(posedge clk) disable iff (!reset_n)
        (staticLol_r && clearStatic) |=> staticLol_r;
    endproperty
    a_clearWhileHigh: assert property (p_clearWhileHigh) // RULE15
        else $error("clear acted while bit still high");

    property p_pinStatic;
        @(posedge clk) disable iff (!reset_n)
        pinStaticMode |=> (loss_of_lock == $past(staticLol_r));
    endproperty
    a_pinStatic: assert property (p_pinStatic) // RULE11
        else $error("pin does not mirror sticky flag");

    property p_pinLive;
        @(posedge clk) disable iff (!reset_n)
        !pinStaticMode |=>
            (loss_of_lock == $past(state_r == cld_pkg::CLD_ACQUIRE));
    endproperty
    a_pinLive: assert property (p_pinLive) // RULE12
        else $error("pin does not follow live acquisition");

    property p_sysRestart;
        @(posedge clk) disable iff (!reset_n)
        resetFall |=> (state_r == cld_pkg::CLD_ACQUIRE) && (cycCnt_r == '0);
    endproperty
    a_sysRestart: assert property (p_sysRestart) // RULE14
        else $error("system reset did not restart acquisition");

endmodule // cld_lock_detector

`default_nettype wire

/* File: hw/cld_consts.svh */
// Constants for the lock detector: window sizes, cycle counts, thresholds.
// Assumes inclusion by bare name from the lock detector sources.
`ifndef CLD_CONSTS_SVH
`define CLD_CONSTS_SVH

// Clock rate of the recovered oscillator domain, in kHz
`define CLD_CLK_KHZ          250000
// Thresholds in ppm: assert above upper, release within lower
`define CLD_UPPER_PPM        1000
`define CLD_LOWER_PPM        250
// Frequency error scale: one million ppm
`define CLD_PPM_SCALE        1000000
// Oscillator cycles per data-marker event at nominal rate
`define CLD_DATA_CYC_PER_EVT 40
// Oscillator cycles per prescaled reference event, before ratio shift
`define CLD_REF_CYC_PER_EVT  16
// Events per measurement window
`define CLD_WIN_EVENTS       2048
// Largest divide-ratio exponent (ratio of 256)
`define CLD_RATIO_MAX        4'h8
// Field widths
`define CLD_RANGE_W          2
`define CLD_RATIO_W          4
`define CLD_CNT_W            40

`endif

/* File: hw/cld_pkg.sv */
// Types for the lock detector.
// Assumes no other package; the header holds the numbers.
package cld_pkg;

    // Lock state, one-hot
    typedef enum logic [1:0] {
        CLD_ACQUIRE = 2'b01,
        CLD_TRACK   = 2'b10
    } cld_state_t;

endpackage

/* File: tb/cld_marker_src.sv */
// Behavioural marker source for the data stream or the reference clock.
// Assumes the bench sets the average period in ps; zero stops the line.
`timescale 1ns/1ns
`default_nettype none

module cld_marker_src #(
    parameter int PHASE_NS = 1
) (
    // Average period in picoseconds
    input  wire logic [31:0] periodPs,
    // Marker line, unrelated in phase to clk
    output logic             lineOut
);
    // Remainder is carried so the average rate is exact on a 1 ns grid
    initial begin : gen
        int acc;
        int d;
        acc = 0;
        lineOut = 1'h0;
        #PHASE_NS;
        forever begin
            if (periodPs == 32'h0) begin
                lineOut = 1'h0;
                #4;
            end else begin
                acc = acc + int'(periodPs);
                d = acc / 1000;
                acc = acc - d * 1000;
                lineOut = 1'h1;
                #(d / 2);
                lineOut = 1'h0;
                #(d - d / 2);
            end
        end
    end
endmodule // cld_marker_src
`default_nettype wire

/* File: tb/cld_testbench.sv */
// Self-checking bench for the lock detector: data and reference modes,
// hysteresis, sticky flag, pin mode and sequenced reset.
// Assumes short windows (64 events) so the run stays near 66k cycles.
`timescale 1ns/1ns
`default_nettype none
`include "cld_consts.svh"

module testbench;
    localparam int WIN_CYC = 64 * 100;
    localparam int REF_WIN = 64 * 64;
    localparam int TIMEOUT = 95000;

    // Design inputs
    logic                    clk, reset_n, lockToRef, pinStaticMode;
    logic                    clearStatic, systemReset;
    logic [`CLD_RANGE_W-1:0] refRange;
    logic [`CLD_RATIO_W-1:0] divRatio;
    // Design outputs and marker lines
    wire logic               lossOfLock, lolStatus, staticLol;
    wire logic               fllEnable, phaseLoopEnable, dataMk, refMk;
    logic [31:0]             dataPs, refPs;
    int                      failures, checkCount, cycles;

    cld_lock_detector #(.WIN_EVENTS(64), .DATA_CYC_PER_EVT(100),
        .REF_CYC_PER_EVT(16)) u_dut (
        .clk(clk), .reset_n(reset_n), .dataMarker(dataMk),
        .reference_clock_input(refMk), .lockToRef(lockToRef),
        .refRange(refRange), .divRatio(divRatio),
        .pinStaticMode(pinStaticMode), .clearStatic(clearStatic),
        .systemReset(systemReset), .loss_of_lock(lossOfLock),
        .lolStatus(lolStatus), .staticLol(staticLol),
        .fllEnable(fllEnable), .phaseLoopEnable(phaseLoopEnable));
    cld_marker_src #(.PHASE_NS(1)) u_dataSrc (
        .periodPs(dataPs), .lineOut(dataMk));
    cld_marker_src #(.PHASE_NS(3)) u_refSrc (
        .periodPs(refPs), .lineOut(refMk));

    // Free-running 250 MHz clock
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string what, input logic exp, input logic seen);
        checkCount++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %b seen %b", what, exp, seen);
        end
    endtask

    // Bounded wait on the acquiring flag, then let all outputs settle
    task automatic waitLol(input logic want, input int maxCyc);
        int n;
        n = 0;
        while (lolStatus !== want && n < maxCyc) begin
            tick(1);
            n++;
        end
        tick(2);
    endtask

    task automatic summarize;
        $display("Checks %0d, mismatches %0d", checkCount, failures);
        if (failures == 0 && checkCount > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Hang guard: a stuck wait ends the run as a failure
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT) begin
            failures++;
            summarize();
        end
    end

    initial begin
        failures = 0;
        checkCount = 0;
        cycles = 0;
        reset_n = 1'h0;
        {lockToRef, pinStaticMode, clearStatic, systemReset} = 4'h0;
        refRange = 2'h0;
        divRatio = 4'h0;
        dataPs = 32'h61a80; // 400000 ps, nominal data rate
        refPs = 32'h1f400;  // 128000 ps, ignored in data mode
        repeat (8) @(posedge clk);
        reset_n <= 1'h1;
        tick(1);
        chk("lossOfLock", 1'h1, lossOfLock);
        chk("staticLol", 1'h0, staticLol);
        chk("phaseLoopEnable", 1'h0, phaseLoopEnable);
        // Lock to data alone
        waitLol(1'h0, 3 * WIN_CYC);
        chk("lolStatus", 1'h0, lolStatus);
        chk("fllEnable", 1'h0, fllEnable);
        chk("phaseLoopEnable", 1'h1, phaseLoopEnable);
        chk("lossOfLock", 1'h0, lossOfLock);
        chk("staticLol", 1'h0, staticLol);
        // Error between thresholds keeps lock
        dataPs = 32'h61b7a; // 400250 ps, four cycles a window
        tick(2 * WIN_CYC + 100);
        chk("lolStatus", 1'h0, lolStatus);
        // Error over the upper threshold drops lock
        dataPs = 32'h61cf1; // 400625 ps, ten cycles a window
        waitLol(1'h1, 3 * WIN_CYC);
        chk("fllEnable", 1'h1, fllEnable);
        chk("lossOfLock", 1'h1, lossOfLock);
        chk("staticLol", 1'h1, staticLol);
        // Between thresholds again: loss persists
        dataPs = 32'h61b7a;
        tick(2 * WIN_CYC + 100);
        chk("lolStatus", 1'h1, lolStatus);
        dataPs = 32'h61a80;
        waitLol(1'h0, 3 * WIN_CYC);
        chk("phaseLoopEnable", 1'h1, phaseLoopEnable);
        chk("staticLol", 1'h1, staticLol);
        // Pin mirrors the sticky flag; clear acts on the fall only
        @(posedge clk) pinStaticMode <= 1'h1;
        tick(2);
        chk("lossOfLock", 1'h1, lossOfLock);
        @(posedge clk) clearStatic <= 1'h1;
        tick(4);
        chk("staticLol", 1'h1, staticLol);
        @(posedge clk) clearStatic <= 1'h0;
        tick(3);
        chk("staticLol", 1'h0, staticLol);
        chk("lossOfLock", 1'h0, lossOfLock);
        // Sequenced system reset restarts acquisition, keeps pin mode
        @(posedge clk) systemReset <= 1'h1;
        tick(4);
        chk("phaseLoopEnable", 1'h1, phaseLoopEnable);
        @(posedge clk) systemReset <= 1'h0;
        tick(3);
        chk("lolStatus", 1'h1, lolStatus);
        chk("fllEnable", 1'h1, fllEnable);
        tick(3);
        chk("lossOfLock", 1'h1, lossOfLock);
        // Reference mode with the data line stopped
        @(posedge clk) begin
            pinStaticMode <= 1'h0;
            lockToRef <= 1'h1;
            refRange <= 2'h1;
            divRatio <= 4'h2;
        end
        dataPs = 32'h0;
        waitLol(1'h0, 3 * REF_WIN);
        chk("lolStatus", 1'h0, lolStatus);
        chk("phaseLoopEnable", 1'h1, phaseLoopEnable);
        chk("lossOfLock", 1'h0, lossOfLock);
        refPs = 32'h1fbd0; // 130000 ps, well over the upper threshold
        waitLol(1'h1, 3 * REF_WIN);
        chk("fllEnable", 1'h1, fllEnable);
        chk("lossOfLock", 1'h1, lossOfLock);
        // Unscaled reference with a ratio of two: one event per edge
        @(posedge clk) begin
            refRange <= 2'h0;
            divRatio <= 4'h1;
        end
        refPs = 32'h1f400;
        waitLol(1'h0, 3 * REF_WIN);
        chk("lolStatus", 1'h0, lolStatus);
        chk("lossOfLock", 1'h0, lossOfLock);
        summarize();
    end
endmodule // testbench
`default_nettype wire
